// ==== core/asr_receiver.sv ====
// asynchronous serial receiver with register file and interrupt logic
// Overview of operation
// - line sampled at sixteen times bit rate; shifter advances once per bit
// - receive polarity bit inverts the pin before data recovery
// - port works asynchronously when sync bit clear and port enable set
// - characters accepted only while continuous receive enable is set
// - completed character sets receive flag; request needs its enable
// - ninth bit and error flags appear in receive status register
// - eight data bits presented in the receive buffer register
// - clearing continuous receive enable clears pending errors
// - nine-bit plus address detect enable selects address detect mode
// - without address detect every character is loaded and flagged while the receive and overrun flags are clear
// - request reaches core only with global and peripheral enables set
// - receive priority bit routes request to high or low line
// - baud control layout: overflow, idle, invert bits, div16, 0, wake, auto (overflow bit always reads 0 here)
// - baud divisor held in high and low byte registers
// - frame is start bit, eight or nine data bits, one stop bit
// - data arrives least significant bit first
// - baud generator runs at x16 or x64 of bit rate by speed bits
//
// Local design decisions: the register addresses and the plain strobed port.
`default_nettype none
module asr_receiver (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [asr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [asr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [asr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic rx_pin,
  output logic irq,
  output logic rx_irq_high,
  output logic rx_irq_low
);
  logic [7:0] core_irq_r, irq_en_r, irq_prio_r, tx_buf_r, div_hi_r, div_lo_r;
  logic [7:0] rx_buffer_r, rdata_r;
  logic port_enable_r, nine_bit_receive_r, single_receive_enable_r;
  logic continuous_receive_enable_r, address_detect_enable_r;
  logic framing_error_flag_r, overrun_error_flag_r, received_ninth_bit_r;
  logic receive_irq_flag_r;
  logic sync_mode_r, high_speed_baud_r, sixteen_bit_divisor_select_r;
  logic rx_polarity_invert_r, tx_polarity_invert_r;
  logic wakeup_enable_r, autobaud_enable_r;
  logic [asr_pkg::EVT_W-1:0] evt_status_r, evt_mask_r, evt_set;
  logic [15:0] brg_cnt_r, divisor;
  logic [1:0] pre_r;
  logic brg_tick, os_tick;
  asr_pkg::asr_state_t state_r;
  logic [3:0] os_cnt_r, bit_cnt_r, nbits;
  logic [8:0] shift_r;
  logic rx_line, rx_en, char_done, stop_bit, ninth, addr_drop;
  logic char_load, overrun_hit, buf_read, rx_req;
  logic [7:0] char_data;

  function automatic logic wr_hit(input logic [3:0] a);
    wr_hit = reg_wr && (reg_addr == a);
  endfunction

  // plain control registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_irq_r <= 8'h00;
      irq_en_r <= 8'h00;
      irq_prio_r <= 8'h00;
      tx_buf_r <= 8'h00;
      div_hi_r <= 8'h00;
      div_lo_r <= 8'h00;
      evt_mask_r <= '0;
    end else begin
      if (wr_hit(asr_pkg::A_CORE_IRQ)) begin
        core_irq_r <= reg_wdata;
      end
      if (wr_hit(asr_pkg::A_IRQ_ENABLES)) begin
        irq_en_r <= reg_wdata;
      end
      if (wr_hit(asr_pkg::A_IRQ_PRIORITY)) begin
        irq_prio_r <= reg_wdata;
      end
      if (wr_hit(asr_pkg::A_TX_BUFFER)) begin
        tx_buf_r <= reg_wdata;
      end
      if (wr_hit(asr_pkg::A_DIV_HIGH)) begin
        div_hi_r <= reg_wdata;
      end
      if (wr_hit(asr_pkg::A_DIV_LOW)) begin
        div_lo_r <= reg_wdata;
      end
      if (wr_hit(asr_pkg::A_EVT_MASK)) begin
        evt_mask_r <= reg_wdata[asr_pkg::EVT_W-1:0];
      end
    end
  end

  // receive, transmit and baud control bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_enable_r <= 1'b0;
      nine_bit_receive_r <= 1'b0;
      single_receive_enable_r <= 1'b0;
      continuous_receive_enable_r <= 1'b0;
      address_detect_enable_r <= 1'b0;
      sync_mode_r <= 1'b0;
      high_speed_baud_r <= 1'b0;
      sixteen_bit_divisor_select_r <= 1'b0;
      rx_polarity_invert_r <= 1'b0;
      tx_polarity_invert_r <= 1'b0;
      wakeup_enable_r <= 1'b0;
      autobaud_enable_r <= 1'b0;
    end else begin
      if (wr_hit(asr_pkg::A_RX_STATUS)) begin
        port_enable_r <= reg_wdata[asr_pkg::B_PORT_EN];
        nine_bit_receive_r <= reg_wdata[asr_pkg::B_NINE_RX];
        single_receive_enable_r <= reg_wdata[asr_pkg::B_SINGLE_RX];
        continuous_receive_enable_r <= reg_wdata[asr_pkg::B_CONT_RX];
        address_detect_enable_r <= reg_wdata[asr_pkg::B_ADDR_DET];
      end
      if (wr_hit(asr_pkg::A_TX_STATUS)) begin
        sync_mode_r <= reg_wdata[asr_pkg::B_SYNC_MODE];
        high_speed_baud_r <= reg_wdata[asr_pkg::B_HIGH_SPEED];
      end
      if (wr_hit(asr_pkg::A_BAUD_CTRL)) begin
        // wake-up and auto-baud are stored only; their engines are absent
        rx_polarity_invert_r <= reg_wdata[asr_pkg::B_RX_INV];
        tx_polarity_invert_r <= reg_wdata[asr_pkg::B_TX_INV];
        sixteen_bit_divisor_select_r <= reg_wdata[asr_pkg::B_DIV16];
        wakeup_enable_r <= reg_wdata[asr_pkg::B_WAKE];
        autobaud_enable_r <= reg_wdata[asr_pkg::B_AUTOBAUD];
      end
    end
  end

  // baud generator: one tick per divisor+1 clocks
  assign divisor = sixteen_bit_divisor_select_r ? {div_hi_r, div_lo_r}
                                                : {8'h00, div_lo_r};
  assign brg_tick = (brg_cnt_r == 16'h0000);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      brg_cnt_r <= 16'h0000;
    end else if (brg_tick || !port_enable_r) begin
      brg_cnt_r <= divisor;
    end else begin
      brg_cnt_r <= brg_cnt_r - 16'h0001;
    end
  end

  // x64 mode divides by four so recovery always sees x16 ticks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= 2'h0;
    end else if (brg_tick) begin
      pre_r <= pre_r + 2'h1;
    end
  end
  assign os_tick = brg_tick && (high_speed_baud_r ||
                   pre_r == asr_pkg::PRE_LAST);

  // receive line recovery
  assign rx_line = rx_pin ^ rx_polarity_invert_r;
  // overrun stalls reception until the enable is cycled
  assign rx_en = port_enable_r && !sync_mode_r &&
                 continuous_receive_enable_r &&
                 !overrun_error_flag_r;
  assign nbits = nine_bit_receive_r ? asr_pkg::BITS_NINE
                                    : asr_pkg::BITS_EIGHT;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= asr_pkg::RX_IDLE;
      os_cnt_r <= 4'h0;
      bit_cnt_r <= 4'h0;
      shift_r <= 9'h000;
    end else if (!rx_en) begin
      state_r <= asr_pkg::RX_IDLE;
      os_cnt_r <= 4'h0;
    end else if (os_tick) begin
      case (state_r)
        asr_pkg::RX_IDLE: begin
          os_cnt_r <= 4'h0;
          if (!rx_line) begin
            state_r <= asr_pkg::RX_START;
          end
        end
        asr_pkg::RX_START: begin
          os_cnt_r <= os_cnt_r + 4'h1;
          if (os_cnt_r == asr_pkg::OS_MID) begin
            // glitch shorter than half a bit is rejected
            os_cnt_r <= 4'h0;
            bit_cnt_r <= 4'h0;
            state_r <= rx_line ? asr_pkg::RX_IDLE : asr_pkg::RX_DATA;
          end
        end
        asr_pkg::RX_DATA: begin
          os_cnt_r <= os_cnt_r + 4'h1;
          if (os_cnt_r == asr_pkg::OS_LAST) begin
            shift_r <= {rx_line, shift_r[8:1]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == nbits - 4'h1) begin
              state_r <= asr_pkg::RX_STOP;
            end
          end
        end
        default: begin
          os_cnt_r <= os_cnt_r + 4'h1;
          if (os_cnt_r == asr_pkg::OS_LAST) begin
            state_r <= asr_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  assign char_done = rx_en && os_tick && state_r == asr_pkg::RX_STOP &&
                     os_cnt_r == asr_pkg::OS_LAST;
  assign stop_bit = rx_line;
  assign char_data = nine_bit_receive_r ? shift_r[7:0] : shift_r[8:1];
  assign ninth = nine_bit_receive_r && shift_r[8];
  assign addr_drop = nine_bit_receive_r && address_detect_enable_r &&
                     !shift_r[8];
  assign overrun_hit = char_done && !addr_drop &&
                       receive_irq_flag_r;
  assign char_load = char_done && !addr_drop &&
                     !receive_irq_flag_r;
  assign buf_read = reg_rd && (reg_addr == asr_pkg::A_RX_BUFFER);

  // receive buffer, ninth bit and framing status travel together
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_buffer_r <= 8'h00;
      received_ninth_bit_r <= 1'b0;
    end else if (char_load) begin
      rx_buffer_r <= char_data;
      received_ninth_bit_r <= ninth;
    end
  end

  // framing flag follows each loaded character; cleared with the enable
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      framing_error_flag_r <= 1'b0;
    end else if (char_load) begin
      framing_error_flag_r <= !stop_bit;
    end else if (!continuous_receive_enable_r) begin
      framing_error_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_error_flag_r <= 1'b0;
    end else if (overrun_hit) begin
      overrun_error_flag_r <= 1'b1;
    end else if (!continuous_receive_enable_r) begin
      overrun_error_flag_r <= 1'b0;
    end
  end

  // reading the buffer empties it; a new load in that cycle wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_irq_flag_r <= 1'b0;
    end else if (char_load) begin
      receive_irq_flag_r <= 1'b1;
    end else if (buf_read) begin
      receive_irq_flag_r <= 1'b0;
    end
  end

  // sticky event status, write one to clear, set wins
  assign evt_set = {overrun_hit, char_load && !stop_bit, char_load};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_status_r <= '0;
    end else if (wr_hit(asr_pkg::A_EVT_STATUS)) begin
      evt_status_r <= (evt_status_r & ~reg_wdata[asr_pkg::EVT_W-1:0]) |
                      evt_set;
    end else begin
      evt_status_r <= evt_status_r | evt_set;
    end
  end
  assign irq = |(evt_status_r & evt_mask_r);

  assign rx_req = receive_irq_flag_r && irq_en_r[asr_pkg::B_RX_IRQ] &&
                  core_irq_r[asr_pkg::B_GLOBAL_IRQ_EN] &&
                  core_irq_r[asr_pkg::B_PERIPH_IRQ_EN];
  assign rx_irq_high = rx_req && irq_prio_r[asr_pkg::B_RX_IRQ];
  assign rx_irq_low = rx_req && !irq_prio_r[asr_pkg::B_RX_IRQ];

  // read port, data valid the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == asr_pkg::A_CORE_IRQ) begin
        rdata_r <= core_irq_r;
      end else if (reg_addr == asr_pkg::A_IRQ_FLAGS) begin
        // transmit flag reads set: the buffer is always free here
        rdata_r <= {2'h0, receive_irq_flag_r, 1'b1, 4'h0};
      end else if (reg_addr == asr_pkg::A_IRQ_ENABLES) begin
        rdata_r <= irq_en_r;
      end else if (reg_addr == asr_pkg::A_IRQ_PRIORITY) begin
        rdata_r <= irq_prio_r;
      end else if (reg_addr == asr_pkg::A_RX_STATUS) begin
        rdata_r <= {port_enable_r, nine_bit_receive_r,
                    single_receive_enable_r, continuous_receive_enable_r,
                    address_detect_enable_r, framing_error_flag_r,
                    overrun_error_flag_r, received_ninth_bit_r};
      end else if (reg_addr == asr_pkg::A_RX_BUFFER) begin
        rdata_r <= rx_buffer_r;
      end else if (reg_addr == asr_pkg::A_TX_BUFFER) begin
        rdata_r <= tx_buf_r;
      end else if (reg_addr == asr_pkg::A_TX_STATUS) begin
        rdata_r <= {3'h0, sync_mode_r, 1'b0, high_speed_baud_r, 1'b1, 1'b0};
      end else if (reg_addr == asr_pkg::A_BAUD_CTRL) begin
        rdata_r <= {1'b0, state_r == asr_pkg::RX_IDLE, rx_polarity_invert_r,
                    tx_polarity_invert_r, sixteen_bit_divisor_select_r,
                    1'b0, wakeup_enable_r, autobaud_enable_r};
      end else if (reg_addr == asr_pkg::A_DIV_HIGH) begin
        rdata_r <= div_hi_r;
      end else if (reg_addr == asr_pkg::A_DIV_LOW) begin
        rdata_r <= div_lo_r;
      end else if (reg_addr == asr_pkg::A_EVT_STATUS) begin
        rdata_r <= {5'h00, evt_status_r};
      end else if (reg_addr == asr_pkg::A_EVT_MASK) begin
        rdata_r <= {5'h00, evt_mask_r};
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end
  assign reg_rdata = rdata_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  receive_irq_flag_set_a: assert property (char_load |=> receive_irq_flag_r)
    else $error("receive flag not set after load");
  receive_irq_flag_read_a: assert property (
    buf_read && !char_load && receive_irq_flag_r |=> !receive_irq_flag_r)
    else $error("receive flag not cleared by buffer read");
  buf_data_a: assert property (char_load |=>
    rx_buffer_r == $past(char_data))
    else $error("buffer not loaded with character");
  overrun_set_a: assert property (
    char_done && !addr_drop && receive_irq_flag_r |=> overrun_error_flag_r)
    else $error("overrun not flagged");
  frame_err_a: assert property (char_load && !stop_bit |=>
    framing_error_flag_r)
    else $error("framing error not flagged");
  continuous_receive_enable_clear_a: assert property (
    !continuous_receive_enable_r && !char_load |=> !overrun_error_flag_r &&
    !framing_error_flag_r)
    else $error("errors survive receive disable");
  addr_drop_a: assert property (char_done && addr_drop |=>
    $stable(rx_buffer_r) && $stable(received_ninth_bit_r))
    else $error("address filtered character was loaded");
  irq_route_a: assert property (rx_irq_high || rx_irq_low |->
    core_irq_r[asr_pkg::B_GLOBAL_IRQ_EN] &&
    core_irq_r[asr_pkg::B_PERIPH_IRQ_EN] &&
    rx_irq_high == irq_prio_r[asr_pkg::B_RX_IRQ])
    else $error("receive request routed wrongly");
  rd_data_a: assert property (
    buf_read |=> reg_rdata == $past(rx_buffer_r))
    else $error("buffer read returned wrong data");
  start_edge_a: assert property (rx_en && os_tick &&
    state_r == asr_pkg::RX_IDLE && (rx_pin ^ rx_polarity_invert_r) == 1'b0
    |=> state_r == asr_pkg::RX_START)
    else $error("start edge not detected");
  port_off_a: assert property (!port_enable_r |=>
    state_r == asr_pkg::RX_IDLE)
    else $error("receiver active with port disabled");

  char_load_c: cover property (char_load);
  overrun_c: cover property (overrun_hit);
  addr_drop_c: cover property (char_done && addr_drop);
  frame_err_c: cover property (char_load && !stop_bit);
endmodule
`default_nettype wire

// ==== shared/asr_pkg.sv ====
// package of register map, field positions and states for the serial receiver
`default_nettype none
package asr_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // register indices (byte-wide registers, one per address)
  localparam logic [3:0] A_CORE_IRQ = 4'h0;
  localparam logic [3:0] A_IRQ_FLAGS = 4'h1;
  localparam logic [3:0] A_IRQ_ENABLES = 4'h2;
  localparam logic [3:0] A_IRQ_PRIORITY = 4'h3;
  localparam logic [3:0] A_RX_STATUS = 4'h4;
  localparam logic [3:0] A_RX_BUFFER = 4'h5;
  localparam logic [3:0] A_TX_BUFFER = 4'h6;
  localparam logic [3:0] A_TX_STATUS = 4'h7;
  localparam logic [3:0] A_BAUD_CTRL = 4'h8;
  localparam logic [3:0] A_DIV_HIGH = 4'h9;
  localparam logic [3:0] A_DIV_LOW = 4'hA;
  localparam logic [3:0] A_EVT_STATUS = 4'hB;
  localparam logic [3:0] A_EVT_MASK = 4'hC;
  // core interrupt control
  localparam int B_GLOBAL_IRQ_EN = 7;
  localparam int B_PERIPH_IRQ_EN = 6;
  // flags / enables / priority share one layout
  localparam int B_RX_IRQ = 5;
  localparam int B_TX_IRQ = 4;
  // receive status and control
  localparam int B_PORT_EN = 7;
  localparam int B_NINE_RX = 6;
  localparam int B_SINGLE_RX = 5;
  localparam int B_CONT_RX = 4;
  localparam int B_ADDR_DET = 3;
  localparam int B_FRAME_ERR = 2;
  localparam int B_OVERRUN = 1;
  localparam int B_NINTH = 0;
  // transmit status and control
  localparam int B_SYNC_MODE = 4;
  localparam int B_HIGH_SPEED = 2;
  localparam int B_SHIFT_EMPTY = 1;
  // baud control
  localparam int B_RX_IDLE = 6;
  localparam int B_RX_INV = 5;
  localparam int B_TX_INV = 4;
  localparam int B_DIV16 = 3;
  localparam int B_WAKE = 1;
  localparam int B_AUTOBAUD = 0;
  localparam logic [7:0] BAUD_CTRL_WMASK = 8'h3B;
  // event status / mask bits
  localparam int E_CHAR = 0;
  localparam int E_FRAME = 1;
  localparam int E_OVERRUN = 2;
  localparam int EVT_W = 3;
  // oversampling
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [1:0] PRE_LAST = 2'h3;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asr_state_t;
endpackage
`default_nettype wire

// ==== verif/asr_line_tx.sv ====
// remote asynchronous transmitter model driving the receive pin
`default_nettype none
module asr_line_tx (
  input wire logic core_clk,
  input wire logic invert,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lvl_r = 1'b1;
  // an inverting line buffer shows up as an inverted pin
  assign line = lvl_r ^ invert;
  task automatic send(input logic [8:0] d, input logic nine,
                      input logic bad_stop, input int bit_clks);
    int n;
    n = nine ? 9 : 8;
    // every level change lands on a rising edge, like any other input
    @(posedge core_clk);
    lvl_r <= 1'b0;
    repeat (bit_clks) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      lvl_r <= d[i];
      repeat (bit_clks) @(posedge core_clk);
    end
    lvl_r <= ~bad_stop;
    repeat (bit_clks) @(posedge core_clk);
    // idle gap so the next start edge is always clean
    lvl_r <= 1'b1;
    repeat (bit_clks) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ==== verif/asr_receiver_tb.sv ====
// self-checking bench for the serial receiver
`default_nettype none
module asr_receiver_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [asr_pkg::ADDR_W-1:0] reg_addr = 4'h0;
  logic [asr_pkg::DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [asr_pkg::DATA_W-1:0] reg_rdata;
  logic rx_pin;
  logic irq;
  logic rx_irq_high;
  logic rx_irq_low;
  logic inv = 1'b0;
  logic [7:0] rv;
  int mismatches = 0;
  int comparisons = 0;
  always #50 core_clk = ~core_clk;
  asr_receiver dut (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin), .irq(irq),
    .rx_irq_high(rx_irq_high), .rx_irq_low(rx_irq_low));
  asr_line_tx far (.core_clk(core_clk), .invert(inv), .line(rx_pin));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    rd(a);
    check(rv, exp);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic outs(input logic hi, input logic lo);
    check({7'h00, rx_irq_high}, {7'h00, hi});
    check({7'h00, rx_irq_low}, {7'h00, lo});
  endtask
  // x16 sampling at one clock per baud tick: 16 clocks per bit
  task automatic setup(input logic [7:0] ctl);
    wr(asr_pkg::A_TX_STATUS, 8'h04);
    wr(asr_pkg::A_DIV_LOW, 8'h00);
    wr(asr_pkg::A_RX_STATUS, ctl);
    ticks(4);
  endtask
  task automatic t_reset();
    rdchk(asr_pkg::A_RX_STATUS, 8'h00);
    rdchk(asr_pkg::A_IRQ_FLAGS, 8'h10);
    rdchk(asr_pkg::A_TX_STATUS, 8'h02);
    wr(4'hD, 8'hFF);
    rdchk(4'hD, 8'h00);
    wr(asr_pkg::A_RX_BUFFER, 8'h5A);
    rdchk(asr_pkg::A_RX_BUFFER, 8'h00);
    wr(asr_pkg::A_BAUD_CTRL, 8'hFF);
    // receiver is off, so the idle bit must read one
    rdchk(asr_pkg::A_BAUD_CTRL, 8'h7B);
    wr(asr_pkg::A_BAUD_CTRL, 8'h00);
    wr(asr_pkg::A_DIV_HIGH, 8'h5A);
    rdchk(asr_pkg::A_DIV_HIGH, 8'h5A);
    wr(asr_pkg::A_DIV_HIGH, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_basic();
    wr(asr_pkg::A_IRQ_ENABLES, 8'h20);
    wr(asr_pkg::A_IRQ_PRIORITY, 8'h20);
    wr(asr_pkg::A_CORE_IRQ, 8'hC0);
    wr(asr_pkg::A_EVT_MASK, 8'h01);
    setup(8'h90);
    far.send(9'h0A5, 1'b0, 1'b0, 16);
    ticks(4);
    outs(1'b1, 1'b0);
    check({7'h00, irq}, 8'h01);
    wr(asr_pkg::A_CORE_IRQ, 8'h80);
    outs(1'b0, 1'b0);
    wr(asr_pkg::A_CORE_IRQ, 8'h40);
    outs(1'b0, 1'b0);
    wr(asr_pkg::A_CORE_IRQ, 8'hC0);
    wr(asr_pkg::A_IRQ_PRIORITY, 8'h00);
    outs(1'b0, 1'b1);
    wr(asr_pkg::A_IRQ_ENABLES, 8'h00);
    outs(1'b0, 1'b0);
    wr(asr_pkg::A_IRQ_ENABLES, 8'h20);
    rdchk(asr_pkg::A_IRQ_FLAGS, 8'h30);
    rdchk(asr_pkg::A_RX_BUFFER, 8'hA5);
    rdchk(asr_pkg::A_IRQ_FLAGS, 8'h10);
    outs(1'b0, 1'b0);
    wr(asr_pkg::A_EVT_MASK, 8'h00);
    check({7'h00, irq}, 8'h00);
    wr(asr_pkg::A_EVT_MASK, 8'h01);
    check({7'h00, irq}, 8'h01);
    wr(asr_pkg::A_EVT_STATUS, 8'h01);
    check({7'h00, irq}, 8'h00);
    rdchk(asr_pkg::A_EVT_STATUS, 8'h00);
    wr(asr_pkg::A_RX_STATUS, 8'h00);
    $display("test basic done");
  endtask
  task automatic t_disabled();
    setup(8'h80);
    far.send(9'h03C, 1'b0, 1'b0, 16);
    rdchk(asr_pkg::A_IRQ_FLAGS, 8'h10);
    setup(8'h10);
    far.send(9'h03C, 1'b0, 1'b0, 16);
    rdchk(asr_pkg::A_IRQ_FLAGS, 8'h10);
    wr(asr_pkg::A_TX_STATUS, 8'h14);
    wr(asr_pkg::A_RX_STATUS, 8'h90);
    far.send(9'h03C, 1'b0, 1'b0, 16);
    rdchk(asr_pkg::A_IRQ_FLAGS, 8'h10);
    wr(asr_pkg::A_RX_STATUS, 8'h00);
    $display("test disabled done");
  endtask
  task automatic t_invert();
    wr(asr_pkg::A_BAUD_CTRL, 8'h20);
    inv = 1'b1;
    setup(8'h90);
    far.send(9'h03C, 1'b0, 1'b0, 16);
    ticks(4);
    rdchk(asr_pkg::A_RX_BUFFER, 8'h3C);
    wr(asr_pkg::A_RX_STATUS, 8'h00);
    wr(asr_pkg::A_BAUD_CTRL, 8'h00);
    inv = 1'b0;
    $display("test invert done");
  endtask
  task automatic t_nine();
    setup(8'hD8);
    far.send(9'h011, 1'b1, 1'b0, 16);
    rdchk(asr_pkg::A_IRQ_FLAGS, 8'h10);
    far.send(9'h122, 1'b1, 1'b0, 16);
    ticks(4);
    rdchk(asr_pkg::A_RX_STATUS, 8'hD9);
    rdchk(asr_pkg::A_RX_BUFFER, 8'h22);
    wr(asr_pkg::A_RX_STATUS, 8'hD0);
    far.send(9'h033, 1'b1, 1'b0, 16);
    ticks(4);
    rdchk(asr_pkg::A_IRQ_FLAGS, 8'h30);
    rdchk(asr_pkg::A_RX_STATUS, 8'hD0);
    rdchk(asr_pkg::A_RX_BUFFER, 8'h33);
    wr(asr_pkg::A_RX_STATUS, 8'h00);
    $display("test nine bit done");
  endtask
  task automatic t_errors();
    setup(8'h90);
    far.send(9'h055, 1'b0, 1'b1, 16);
    ticks(4);
    rdchk(asr_pkg::A_RX_STATUS, 8'h94);
    rdchk(asr_pkg::A_EVT_STATUS, 8'h03);
    far.send(9'h066, 1'b0, 1'b0, 16);
    ticks(4);
    // framing stays from the first character, overrun joins it
    rdchk(asr_pkg::A_RX_STATUS, 8'h96);
    rdchk(asr_pkg::A_EVT_STATUS, 8'h07);
    wr(asr_pkg::A_RX_STATUS, 8'h80);
    rdchk(asr_pkg::A_RX_STATUS, 8'h80);
    rdchk(asr_pkg::A_RX_BUFFER, 8'h55);
    wr(asr_pkg::A_EVT_STATUS, 8'h07);
    wr(asr_pkg::A_RX_STATUS, 8'h00);
    $display("test errors done");
  endtask
  // slow x64 sampling, a nonzero divisor at x16, then the 16-bit path;
  // a stray high byte must be ignored while 16-bit select is clear
  task automatic t_baud();
    logic [7:0] hs [3] = '{8'h00, 8'h04, 8'h04};
    logic [7:0] bd [3] = '{8'h00, 8'h00, 8'h08};
    logic [7:0] hi [3] = '{8'h01, 8'h01, 8'h00};
    logic [7:0] lo [3] = '{8'h00, 8'h01, 8'h01};
    int bc [3] = '{64, 32, 32};
    logic [7:0] dat [3] = '{8'hC3, 8'h96, 8'h69};
    for (int k = 0; k < 3; k++) begin
      wr(asr_pkg::A_TX_STATUS, hs[k]);
      wr(asr_pkg::A_BAUD_CTRL, bd[k]);
      wr(asr_pkg::A_DIV_HIGH, hi[k]);
      wr(asr_pkg::A_DIV_LOW, lo[k]);
      wr(asr_pkg::A_RX_STATUS, 8'h90);
      ticks(8);
      far.send({1'b0, dat[k]}, 1'b0, 1'b0, bc[k]);
      ticks(8);
      rdchk(asr_pkg::A_RX_BUFFER, dat[k]);
      wr(asr_pkg::A_RX_STATUS, 8'h00);
    end
    wr(asr_pkg::A_BAUD_CTRL, 8'h00);
    $display("test baud done");
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_basic();
    t_disabled();
    t_invert();
    t_nine();
    t_errors();
    t_baud();
    test_done();
  end
  // the whole run needs well under 10000 clocks
  initial begin
    repeat (30000) @(posedge core_clk);
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
